// ---- hids_cfg.svh ----
`ifndef HIDS_CFG_SVH
`define HIDS_CFG_SVH
// Address byte layout
`define HIDS_DIR_BIT      7
`define HIDS_ADDR_MSB     6
`define HIDS_ADDR_LSB     1
`define HIDS_READ_VAL     1'b1
`define HIDS_FILL_BYTE    8'h00
// Register space and control bit positions
`define HIDS_NREGS        64
`define HIDS_RXCTL_ADDR   6'h0c
`define HIDS_PAROFF_BIT   4
`define HIDS_TPEN_ADDR    6'h33
`define HIDS_LINEEN_BIT   7
`define HIDS_TPEN_RST     8'h80
// Strap levels
`define HIDS_BUSSEL_I2C   1'b1
`define HIDS_ASTRAP_SPI   1'b1
// Host clock divider: half period in host cycles
`define HIDS_SCK_HALF     4'h2
`endif

// ---- hids_pkg.sv ----
package hids_pkg;
  typedef enum logic [1:0] {HIDS_UART, HIDS_SPI, HIDS_I2C, HIDS_NONE} hids_mode_t;
  typedef enum logic [1:0] {HIDS_H_IDLE, HIDS_H_SHIFT, HIDS_H_GAP, HIDS_H_DONE} hids_hst_t;
endpackage

// ---- hids_if.sv ----
`timescale 1ns/1ns
`default_nettype none
interface hids_if;
  logic sck;
  logic select_n;
  logic mosi;
  logic miso_o;
  logic miso_oe;
  modport dev (input sck, input select_n, input mosi, output miso_o, output miso_oe);
  modport host (output sck, output select_n, output mosi, input miso_o, input miso_oe);
endinterface
`default_nettype wire

// ---- hids_sync.sv ----
`timescale 1ns/1ns
`default_nettype none
// Two flip-flop level synchroniser, one per bit
module hids_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rstn_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_r;
  logic [W-1:0] q_r;
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      // First stage feeds only the second stage
      always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
          meta_r[g] <= 1'b0;
          q_r[g]    <= 1'b0;
        end else begin
          meta_r[g] <= d_i[g];
          q_r[g]    <= meta_r[g];
        end
      end
    end
  endgenerate
  assign q_o = q_r;
endmodule
`default_nettype wire

// ---- hids_dev.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "hids_cfg.svh"
module hids_dev (
  hids_if.dev              spi,
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic        bus_select_i,
  input  wire logic        address_strap_i,
  input  wire logic [5:0]  i2c_addr_i,
  input  wire logic        irq_event_i,
  input  wire logic        uart_tx_i,
  input  wire logic        uart_aux_i,
  input  wire logic        uart_rts_i,
  output logic [1:0]       mode_o,
  output logic [5:0]       i2c_addr_o,
  output logic             uart_tx_o,
  output logic             uart_aux_output_o,
  output logic             uart_aux_oe_o,
  output logic             uart_request_to_send_o,
  output logic             uart_rts_oe_o,
  output logic             parity_auto_o,
  output logic             irq_o,
  output logic             wr_stb_o,
  output logic [5:0]       wr_addr_o,
  output logic [7:0]       wr_data_o
);
  // Straps come from pins: synchronise before use
  // The event pin shares the same synchroniser, each bit on its own two stages
  logic [1:0] strap_s;
  logic       irq_s;
  hids_sync #(.W(3)) u_sync (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .d_i    ({bus_select_i, address_strap_i, irq_event_i}),
    .q_o    ({strap_s, irq_s})
  );

  // Mode latched once after reset release; detect phase waits for sync latency
  // Straps are read only here, so moving them later has no effect until the next reset;
  // mode stays at none while the detect phase runs, which keeps every port except uart_tx_o released
  hids_pkg::hids_mode_t mode_r;
  logic [1:0]           det_cnt_r;
  hids_pkg::hids_mode_t mode_nxt;
  wire strap_i2c = (strap_s[1] == `HIDS_BUSSEL_I2C);
  wire strap_spi = (strap_s[0] == `HIDS_ASTRAP_SPI);
  assign mode_nxt = strap_i2c ? hids_pkg::HIDS_I2C :
                    (strap_spi ? hids_pkg::HIDS_SPI : hids_pkg::HIDS_UART);
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      mode_r    <= hids_pkg::HIDS_NONE;
      det_cnt_r <= 2'h0;
    end else if (det_cnt_r != 2'h3) begin
      det_cnt_r <= det_cnt_r + 2'h1;
      if (det_cnt_r == 2'h2) mode_r <= mode_nxt;
    end
  end
  assign mode_o = mode_r;
  wire is_spi  = (mode_r == hids_pkg::HIDS_SPI);
  wire is_uart = (mode_r == hids_pkg::HIDS_UART);

  // Register file lives in the host clock domain
  logic [7:0] regs_r [`HIDS_NREGS];
  logic [7:0] rxctl_r;
  logic [7:0] tpen_r;

  // Link side: runs on SCK, held in reset while select is high
  // Nothing here needs a running SCK outside a frame; the master parks it low
  logic [2:0] bcnt_r;
  logic [6:0] sh_r;
  logic       first_r;
  logic       rd_r;
  logic [5:0] wa_r;
  logic [7:0] wbyte_r;
  logic       wtog_r;
  wire  [7:0] byte_in = {sh_r, spi.mosi};
  wire  [5:0] byte_addr = byte_in[`HIDS_ADDR_MSB:`HIDS_ADDR_LSB];
  always_ff @(posedge spi.sck or posedge spi.select_n) begin
    if (spi.select_n) begin
      bcnt_r  <= 3'h0;
      first_r <= 1'b1;
      sh_r    <= 7'h00;
      rd_r    <= 1'b0;
      wa_r    <= 6'h00;
    end else begin
      sh_r   <= byte_in[6:0];
      bcnt_r <= bcnt_r + 3'h1;
      if (bcnt_r == 3'h7) begin
        first_r <= 1'b0;
        if (first_r) begin
          rd_r <= (byte_in[`HIDS_DIR_BIT] == `HIDS_READ_VAL);
          wa_r <= byte_addr;
        end else if (rd_r) begin
          wa_r <= byte_addr;
        end
      end
    end
  end
  // Write byte hand-off in the link domain; the toggle marks each completed data byte.
  // It starts known from the host-side reset; select must not clear it, or a byte that
  // ends a frame would vanish before the host side saw the toggle move.
  logic [5:0] wadr_r;
  wire        wr_byte_end = !spi.select_n && bcnt_r == 3'h7 && !first_r && !rd_r;
  always_ff @(posedge spi.sck or negedge rstn_i) begin
    if (!rstn_i) begin
      wbyte_r <= 8'h00;
      wadr_r  <= 6'h00;
      wtog_r  <= 1'b0;
    end else if (wr_byte_end) begin
      wbyte_r <= byte_in;
      wadr_r  <= wa_r;
      wtog_r  <= ~wtog_r;
    end
  end
  // Read data: load on byte boundary, shift out on falling edge
  logic [7:0] tx_r;
  logic       load_r;
  always_ff @(negedge spi.sck or posedge spi.select_n) begin
    if (spi.select_n) begin
      tx_r   <= 8'h00;
      load_r <= 1'b0;
    end else if (bcnt_r == 3'h0 && !first_r && rd_r) begin
      tx_r <= regs_r[wa_r];
    end else begin
      tx_r <= {tx_r[6:0], 1'b0};
    end
  end
  // Released when unselected or not in SPI mode; device never drives SCK
  // Bit 7 of the shift register is the wire; it moves after a falling SCK and clears when select rises
  assign spi.miso_o  = tx_r[7];
  assign spi.miso_oe = is_spi & ~spi.select_n;

  // Write commit: toggle crosses into the host clock domain through two stages,
  // the third stage only serves as the reference for edge detection
  logic [2:0] wt_s;
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      wt_s <= 3'h0;
    end else begin
      wt_s <= {wt_s[1:0], wtog_r};
    end
  end
  wire wr_ev = is_spi & (wt_s[2] ^ wt_s[1]);
  // Address and data are captured with the toggle and hold a full byte after it,
  // so a frame that ends right after its last byte cannot disturb the commit
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      wr_stb_o  <= 1'b0;
      wr_addr_o <= 6'h00;
      wr_data_o <= 8'h00;
    end else begin
      wr_stb_o <= wr_ev;
      if (wr_ev) begin
        wr_addr_o <= wadr_r;
        wr_data_o <= wbyte_r;
      end
    end
  end
  genvar gi;
  generate
    for (gi = 0; gi < `HIDS_NREGS; gi++) begin : g_reg
      // One register per entry; only the line-enable register resets non-zero
      always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
          regs_r[gi] <= (gi == `HIDS_TPEN_ADDR) ? `HIDS_TPEN_RST : 8'h00;
        end else if (wr_ev && wadr_r == 6'(gi)) begin
          regs_r[gi] <= wbyte_r;
        end
      end
    end
  endgenerate
  assign rxctl_r = regs_r[`HIDS_RXCTL_ADDR];
  assign tpen_r  = regs_r[`HIDS_TPEN_ADDR];

  // Parity engine enable and serial line controls
  assign parity_auto_o = ~rxctl_r[`HIDS_PAROFF_BIT];
  wire line_en = tpen_r[`HIDS_LINEEN_BIT];
  assign uart_tx_o              = uart_tx_i;
  assign uart_aux_output_o      = uart_aux_i;
  assign uart_request_to_send_o = uart_rts_i;
  assign uart_aux_oe_o          = is_uart & line_en;
  assign uart_rts_oe_o          = is_uart & line_en;
  // Address pins only meaningful in I2C mode
  assign i2c_addr_o = (mode_r == hids_pkg::HIDS_I2C) ? i2c_addr_i : 6'h00;
  // Interrupt request follows synchronised event level
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= irq_s;
    end
  end
endmodule
`default_nettype wire

// ---- hids_host.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "hids_cfg.svh"
module hids_host (
  hids_if.host             spi,
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic        start_i,
  input  wire logic [7:0]  tx_byte_i,
  input  wire logic        last_i,
  output logic             busy_o,
  output logic             byte_ack_o,
  output logic             rx_valid_o,
  output logic [7:0]       rx_byte_o
);
  hids_pkg::hids_hst_t st_r;
  logic [3:0] div_r;
  logic       sck_r;
  logic       sel_n_r;
  logic [7:0] tx_r;
  logic [7:0] rx_r;
  logic [2:0] bit_r;
  logic       last_r;
  logic       miso_s;
  // MISO is sampled just before our falling SCK, a full half period after the rise,
  // so the two-stage sync already holds the bit that the device launched a period earlier
  hids_sync #(.W(1)) u_sync (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .d_i    (spi.miso_o),
    .q_o    (miso_s)
  );
  wire tick = (div_r == `HIDS_SCK_HALF - 4'h1);
  // Master drives SCK from divider; MOSI changes only while SCK low
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      st_r <= hids_pkg::HIDS_H_IDLE;
      div_r <= 4'h0;
      sck_r <= 1'b0;
      sel_n_r <= 1'b1;
      tx_r <= 8'h00;
      rx_r <= 8'h00;
      bit_r <= 3'h0;
      last_r <= 1'b0;
      byte_ack_o <= 1'b0;
      rx_valid_o <= 1'b0;
      rx_byte_o <= 8'h00;
    end else begin
      byte_ack_o <= 1'b0;
      rx_valid_o <= 1'b0;
      div_r <= tick ? 4'h0 : div_r + 4'h1;
      case (st_r)
        hids_pkg::HIDS_H_IDLE: begin
          div_r <= 4'h0;
          if (start_i) begin
            sel_n_r <= 1'b0;
            tx_r <= tx_byte_i;
            last_r <= last_i;
            byte_ack_o <= 1'b1;
            bit_r <= 3'h0;
            st_r <= hids_pkg::HIDS_H_SHIFT;
          end
        end
        hids_pkg::HIDS_H_SHIFT: if (tick) begin
          sck_r <= ~sck_r;
          if (sck_r) begin
            tx_r <= {tx_r[6:0], 1'b0};
            rx_r <= {rx_r[6:0], miso_s};
            bit_r <= bit_r + 3'h1;
            if (bit_r == 3'h7) begin
              rx_valid_o <= 1'b1;
              rx_byte_o <= {rx_r[6:0], miso_s};
              st_r <= hids_pkg::HIDS_H_GAP;
            end
          end
        end
        hids_pkg::HIDS_H_GAP: begin
          if (last_r) st_r <= hids_pkg::HIDS_H_DONE;
          else begin
            tx_r <= tx_byte_i;
            last_r <= last_i;
            byte_ack_o <= 1'b1;
            st_r <= hids_pkg::HIDS_H_SHIFT;
          end
        end
        hids_pkg::HIDS_H_DONE: if (tick) begin
          sel_n_r <= 1'b1;
          st_r <= hids_pkg::HIDS_H_IDLE;
        end
        default: st_r <= hids_pkg::HIDS_H_IDLE;
      endcase
    end
  end
  assign spi.sck = sck_r;
  assign spi.select_n = sel_n_r;
  assign spi.mosi = tx_r[7];
  assign busy_o = (st_r != hids_pkg::HIDS_H_IDLE);
endmodule
`default_nettype wire

// ---- hids_chk.sv ----
`timescale 1ns/1ns
`default_nettype none
// Wire-level checks on the serial link between the two ends
module hids_chk (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic sck,
  input wire logic select_n,
  input wire logic mosi,
  input wire logic miso_oe
);
  logic [2:0] rise_cnt_r;
  // Rises per frame modulo eight, so a frame has to end on a byte boundary
  always_ff @(posedge clk_i) begin
    if (!rstn_i || select_n) rise_cnt_r <= 3'h0;
    else if ($rose(sck)) rise_cnt_r <= rise_cnt_r + 3'h1;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // Clock starts low after select, then stays high exactly two host cycles and low at least two
  sequence s_lead; !sck; endsequence
  sequence s_rise; ##[1:6] $rose(sck); endsequence
  sequence s_high; sck [*2] ##1 !sck; endsequence
  property p_clk_frame; sck |-> !select_n; endproperty
  property p_start; $fell(select_n) |-> s_lead ##0 s_rise; endproperty
  property p_mosi; $rose(sck) |-> $stable(mosi); endproperty
  property p_high; $rose(sck) |-> s_high; endproperty
  property p_low; $fell(sck) |-> !sck [*2]; endproperty
  property p_bytes; $rose(select_n) |-> rise_cnt_r == 3'h0; endproperty
  property p_oe; select_n && $past(select_n) |-> !miso_oe; endproperty
  property p_end; $rose(select_n) |-> !sck && !$past(sck); endproperty
  a_clk_frame: assert property (p_clk_frame)
    else $error("serial clock active outside a frame");
  a_start: assert property (p_start)
    else $error("frame start without a prompt first clock rise");
  a_mosi: assert property (p_mosi)
    else $error("mosi moved at a rising clock edge");
  a_high: assert property (p_high)
    else $error("clock high phase not two cycles");
  a_low: assert property (p_low)
    else $error("clock low phase too short");
  a_bytes: assert property (p_bytes)
    else $error("frame ended inside a byte");
  a_oe: assert property (p_oe)
    else $error("miso driven while unselected");
  a_end: assert property (p_end)
    else $error("select released with clock not idle");
endmodule
`default_nettype wire

// ---- host_interface_detect_spi_slave_test.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "hids_cfg.svh"
module host_interface_detect_spi_slave_test;
  logic        clk_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic        bus_select_i = 1'b0;
  logic        address_strap_i = 1'b1;
  logic        irq_event_i = 1'b0;
  logic        uart_tx_i = 1'b1;
  logic        uart_aux_i = 1'b0;
  logic        uart_rts_i = 1'b1;
  logic [5:0]  i2c_addr_i = 6'h2d;
  logic        start_i = 1'b0;
  logic        last_i = 1'b0;
  logic [7:0]  tx_byte_i = 8'h00;
  logic [1:0]  mode_o;
  logic [5:0]  i2c_addr_o, wr_addr_o;
  logic [7:0]  wr_data_o, rx_byte_o;
  logic        uart_tx_o, uart_aux_output_o, uart_aux_oe_o, uart_request_to_send_o, uart_rts_oe_o;
  logic        parity_auto_o, irq_o, wr_stb_o, busy_o, byte_ack_o, rx_valid_o;
  logic        oe_seen = 1'b0;
  logic [7:0]  rx_q [$];
  logic [13:0] wr_q [$];
  int          bad_count = 0;
  int          compares = 0;
  // Two ends back to back; the host divides its own clock down to make the serial clock
  hids_if link ();
  hids_dev i_hids_dev (.spi(link.dev), .clk_i, .rstn_i, .bus_select_i, .address_strap_i, .i2c_addr_i,
    .irq_event_i, .uart_tx_i, .uart_aux_i, .uart_rts_i, .mode_o, .i2c_addr_o, .uart_tx_o, .uart_aux_output_o,
    .uart_aux_oe_o, .uart_request_to_send_o, .uart_rts_oe_o, .parity_auto_o, .irq_o, .wr_stb_o, .wr_addr_o,
    .wr_data_o);
  hids_host i_hids_host (.spi(link.host), .clk_i, .rstn_i, .start_i, .tx_byte_i, .last_i, .busy_o,
    .byte_ack_o, .rx_valid_o, .rx_byte_o);
  hids_chk i_hids_chk (.clk_i, .rstn_i, .sck(link.sck), .select_n(link.select_n), .mosi(link.mosi),
    .miso_oe(link.miso_oe));
  // Host clock
  initial begin
    forever #20 clk_i = ~clk_i;
  end
  // Log committed writes and any drive of the data-out wire
  always @(posedge clk_i) begin
    if (wr_stb_o === 1'b1) wr_q.push_back({wr_addr_o, wr_data_o});
    if (link.miso_oe === 1'b1) oe_seen <= 1'b1;
  end
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Bounded wait: 0 byte taken, 1 byte received, 2 link idle
  task automatic wait_on(input int sel);
    for (int n = 0; n < 500; n++) begin
      @(posedge clk_i);
      if (sel == 0 && byte_ack_o === 1'b1) return;
      if (sel == 1 && rx_valid_o === 1'b1) return;
      if (sel == 2 && busy_o === 1'b0 && link.select_n === 1'b1) return;
    end
    bad_count++;
    $display("[FAIL] handshake wait expected 1 seen 0");
    wrap_up();
  endtask
  task automatic do_reset(input int n);
    @(posedge clk_i);
    rstn_i <= 1'b0;
    repeat (n) @(posedge clk_i);
    rstn_i <= 1'b1;
    repeat (8) @(posedge clk_i);
  endtask
  function automatic logic [7:0] ab(input logic rd, input logic [5:0] a);
    return {rd, a, 1'b0};
  endfunction
  // One frame of n bytes; the next byte is offered as soon as the previous one is taken
  task automatic xfer(input logic [7:0] b [4], input int n);
    rx_q.delete();
    @(posedge clk_i);
    start_i <= 1'b1;
    tx_byte_i <= b[0];
    last_i <= (n == 1);
    wait_on(0);
    start_i <= 1'b0;
    if (n > 1) begin
      tx_byte_i <= b[1];
      last_i <= (n == 2);
    end
    for (int i = 0; i < n; i++) begin
      wait_on(1);
      rx_q.push_back(rx_byte_o);
      if (i + 1 < n) begin
        wait_on(0);
        if (i + 2 < n) begin
          tx_byte_i <= b[i + 2];
          last_i <= (i + 3 == n);
        end
      end
    end
    wait_on(2);
    repeat (8) @(posedge clk_i);
  endtask
  // Each strap combination except both high; traffic in UART mode must be ignored
  task automatic t_detect();
    logic [1:0] exp [3] = '{hids_pkg::HIDS_UART, hids_pkg::HIDS_I2C, hids_pkg::HIDS_SPI};
    for (int m = 0; m < 3; m++) begin
      bus_select_i <= (m == 1);
      address_strap_i <= (m == 2);
      do_reset(3);
      check("mode", 16'(exp[m]), 16'(mode_o));
      if (m == 0) begin
        check("uart pins", 16'h0017, 16'({uart_tx_o, uart_aux_output_o, uart_request_to_send_o,
          uart_rts_oe_o, uart_aux_oe_o}));
        wr_q.delete();
        oe_seen <= 1'b0;
        xfer('{ab(1'b0, 6'h15), 8'h5a, 8'h00, 8'h00}, 2);
        check("refused", 16'h0000, 16'({wr_q.size() != 0, oe_seen}));
      end
      if (m == 1) check("i2c pins", 16'h002d, 16'(i2c_addr_o));
      if (m == 2) check("miso idle", 16'h0000, 16'(link.miso_oe));
    end
  endtask
  // Burst write to one address, parity control, then a chained read
  task automatic t_spi();
    check("parity on", 16'h0001, 16'(parity_auto_o));
    wr_q.delete();
    oe_seen <= 1'b0;
    xfer('{ab(1'b0, 6'h15), 8'ha5, 8'h3c, 8'h00}, 3);
    check("write count", 16'h0002, 16'(wr_q.size()));
    check("write 0", {2'h0, 6'h15, 8'ha5}, 16'(wr_q[0]));
    check("write 1", {2'h0, 6'h15, 8'h3c}, 16'(wr_q[1]));
    xfer('{ab(1'b0, `HIDS_RXCTL_ADDR), 8'h01 << `HIDS_PAROFF_BIT, 8'h00, 8'h00}, 2);
    check("parity off", 16'h0000, 16'(parity_auto_o));
    xfer('{ab(1'b1, 6'h15), ab(1'b1, `HIDS_TPEN_ADDR), `HIDS_FILL_BYTE, 8'h00}, 3);
    check("read 1", 16'h003c, 16'(rx_q[1]));
    check("read 2", 16'(`HIDS_TPEN_RST), 16'(rx_q[2]));
    check("miso driven", 16'h0001, 16'(oe_seen));
  endtask
  // Event input must reach the request output after synchronisation
  task automatic t_irq();
    irq_event_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    check("irq set", 16'h0001, 16'(irq_o));
    irq_event_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    check("irq clear", 16'h0000, 16'(irq_o));
  endtask
  initial begin
    do_reset(12);
    t_detect();
    t_spi();
    t_irq();
    wrap_up();
  end
endmodule
`default_nettype wire
